// ### verilog/rsp_pkg.sv
`default_nettype none
package rsp_pkg;

    // ****************************************
    // field and code constants
    // ****************************************
    localparam int RSP_SYM_W = 10;
    localparam int RSP_FIELD_SIZE = 1024;
    localparam int RSP_NPAR = 10;
    localparam int RSP_FIRST_ROOT = 0;
    localparam logic [10:0] RSP_POLY = 11'h409;
    localparam logic [9:0] RSP_ALPHA = 10'h002;
    localparam logic [9:0] RSP_ONE = 10'h001;
    localparam logic [3:0] RSP_PAR_LAST = 4'h9;
    localparam logic [9:0] RSP_SYM_ZERO = 10'h000;

    // generator coefficients, index 0 is the constant term
    localparam logic [10:0][9:0] RSP_GEN = {
        10'h001, 10'h3ff, 10'h0c3, 10'h0af, 10'h2a5, 10'h396,
        10'h1d0, 10'h1cf, 10'h3e5, 10'h1f2, 10'h0a9
    };

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [0:0] {
        RSP_ST_MSG = 1'b0,
        RSP_ST_PAR = 1'b1
    } rsp_state_t;

    typedef logic [9:0][9:0] rsp_pow_t;
    typedef logic [1023:0][9:0] rsp_inv_rom_t;

    typedef struct packed {
        rsp_state_t st;
        logic [3:0] cnt;
        logic [9:0][9:0] rem;
        logic out_valid;
        logic [9:0] out_data;
        logic out_last;
        logic out_par;
        logic [9:0] mul_p;
        logic [9:0] inv_q;
    } rsp_regs_t;

    // ****************************************
    // field functions
    // ****************************************
    // multiply by alpha, reduced by the field polynomial
    function automatic logic [9:0] rsp_gf_xtime(input logic [9:0] s);
        logic [9:0] r;
        r = {s[8:0], 1'b0};
        if (s[9]) begin
            r = r ^ RSP_POLY[9:0];
        end
        return r;
    endfunction

    // shared part of a multiplier: a times alpha^0..alpha^9
    function automatic rsp_pow_t rsp_gf_pows(input logic [9:0] a);
        rsp_pow_t p;
        p[0] = a;
        for (int i = 1; i < RSP_SYM_W; i++) begin
            p[i] = rsp_gf_xtime(p[i-1]);
        end
        return p;
    endfunction

    // reduced per-product part: xor of the shared terms picked by b
    function automatic logic [9:0] rsp_gf_pick(input rsp_pow_t p, input logic [9:0] b);
        logic [9:0] r;
        r = '0;
        for (int i = 0; i < RSP_SYM_W; i++) begin
            if (b[i]) begin
                r = r ^ p[i];
            end
        end
        return r;
    endfunction

    function automatic logic [9:0] rsp_gf_mul(input logic [9:0] a, input logic [9:0] b);
        return rsp_gf_pick(rsp_gf_pows(a), b);
    endfunction

    // reciprocal table, a^1022 by repeated squaring, zero maps to zero
    function automatic rsp_inv_rom_t rsp_build_inv();
        rsp_inv_rom_t t;
        logic [9:0] sq;
        logic [9:0] acc;
        t[0] = '0;
        for (int a = 1; a < RSP_FIELD_SIZE; a++) begin
            sq = a[9:0];
            acc = RSP_ONE;
            for (int k = 1; k < RSP_SYM_W; k++) begin
                sq = rsp_gf_mul(sq, sq);
                acc = rsp_gf_mul(acc, sq);
            end
            t[a] = acc;
        end
        return t;
    endfunction

endpackage
`default_nettype wire

// ### verilog/rsp_encoder.sv
`timescale 1ns/10ps
`default_nettype none
module rsp_encoder
    import rsp_pkg::*;
#(
    parameter int SYM_W = RSP_SYM_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // message stream in
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [9:0] in_data,
    input wire logic in_last,
    // codeword stream out
    output logic out_valid,
    output logic [9:0] out_data,
    output logic out_last,
    output logic out_par,
    // general multiplier
    input wire logic [9:0] mul_a,
    input wire logic [9:0] mul_b,
    output logic [9:0] mul_p,
    // reciprocal lookup
    input wire logic [9:0] inv_a,
    output logic [9:0] inv_q
);

    // ****************************************
    // elaboration check
    // ****************************************
    generate
        if (SYM_W != 10) begin : g_bad_width
            $error("symbol width must be 10");
        end
    endgenerate

    // ****************************************
    // reciprocal rom
    // ****************************************
    // single reciprocal table
    localparam rsp_inv_rom_t INV_ROM = rsp_build_inv();

    // ****************************************
    // feedback products
    // ****************************************
    rsp_regs_t s_q;
    rsp_regs_t s_d;
    logic [9:0] fb;
    rsp_pow_t fb_pow;
    logic [9:0][9:0] fb_prod;

    assign fb = in_data ^ s_q.rem[RSP_NPAR-1];

    assign fb_pow = rsp_gf_pows(fb);

    genvar gi;
    generate
        for (gi = 0; gi < RSP_NPAR; gi++) begin : g_prod
            assign fb_prod[gi] = rsp_gf_pick(fb_pow, RSP_GEN[gi]);
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.out_valid = 1'b0;
        s_d.out_last = 1'b0;
        s_d.out_par = 1'b0;
        s_d.mul_p = rsp_gf_mul(mul_a, mul_b);
        s_d.inv_q = INV_ROM[inv_a];
        unique case (s_q.st)
            RSP_ST_MSG: begin
                if (in_valid) begin
                    s_d.out_valid = 1'b1;
                    s_d.out_data = in_data;
                    s_d.rem[0] = fb_prod[0];
                    for (int i = 1; i < RSP_NPAR; i++) begin
                        s_d.rem[i] = s_q.rem[i-1] ^ fb_prod[i];
                    end
                    if (in_last) begin
                        s_d.st = RSP_ST_PAR;
                        s_d.cnt = '0;
                    end
                end
            end
            RSP_ST_PAR: begin
                s_d.out_valid = 1'b1;
                s_d.out_par = 1'b1;
                s_d.out_data = s_q.rem[RSP_NPAR-1];
                s_d.rem = {s_q.rem[RSP_NPAR-2:0], RSP_SYM_ZERO};
                s_d.cnt = s_q.cnt + 4'h1;
                if (s_q.cnt == RSP_PAR_LAST) begin
                    s_d.out_last = 1'b1;
                    s_d.st = RSP_ST_MSG;
                end
            end
        endcase
    end

    // ****************************************
    // state register
    // ****************************************
    // one xor tree per stage between flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // ten-bit symbols throughout
    assign in_ready = (s_q.st == RSP_ST_MSG);
    assign out_valid = s_q.out_valid;
    assign out_data = s_q.out_data;
    assign out_last = s_q.out_last;
    assign out_par = s_q.out_par;
    assign mul_p = s_q.mul_p;
    assign inv_q = s_q.inv_q;

    // ****************************************
    // checks
    // ****************************************
    logic [9:0] syn0_q;
    logic [9:0] syn1_q;
    logic [9:0] syn1_next;

    assign syn1_next = rsp_gf_mul(syn1_q, RSP_ALPHA) ^ out_data;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syn0_q <= '0;
            syn1_q <= '0;
        end else if (out_valid) begin
            syn0_q <= out_last ? RSP_SYM_ZERO : (syn0_q ^ out_data);
            syn1_q <= out_last ? RSP_SYM_ZERO : syn1_next;
        end
    end

    a_parity_run_len: assert property (@(posedge clk) disable iff (!rstn)
        in_valid && in_ready && in_last |=> !out_par ##1 (out_par && !out_last) [*8]
        ##1 (out_par && !out_last) ##1 (out_par && out_last)
        ##1 !out_par)
        else $error("parity run is not ten symbols");

    a_ready_in_par: assert property (@(posedge clk) disable iff (!rstn)
        out_par && !out_last |-> !in_ready)
        else $error("message accepted during parity");

    a_msg_pass_thru: assert property (@(posedge clk) disable iff (!rstn)
        in_valid && in_ready |=> out_valid && !out_par && out_data == $past(in_data))
        else $error("message symbol altered");

    a_mul_by_one: assert property (@(posedge clk) disable iff (!rstn)
        mul_b == RSP_ONE |=> mul_p == $past(mul_a))
        else $error("multiply by one wrong");

    a_mul_field_wrap: assert property (@(posedge clk) disable iff (!rstn)
        mul_a == 10'h200 && mul_b == RSP_ALPHA |=> mul_p == 10'h009)
        else $error("field reduction wrong");

    a_inv_product_one: assert property (@(posedge clk) disable iff (!rstn)
        inv_a != RSP_SYM_ZERO |=> rsp_gf_mul(inv_q, $past(inv_a)) == RSP_ONE)
        else $error("reciprocal wrong");

    a_shared_mult_eq: assert property (@(posedge clk) disable iff (!rstn)
        fb_prod[3] == rsp_gf_mul(RSP_GEN[3], fb) && fb_prod[0] == rsp_gf_mul(RSP_GEN[0], fb))
        else $error("shared multiplier differs");

    a_root_syndromes: assert property (@(posedge clk) disable iff (!rstn)
        out_valid && out_last |-> (syn0_q ^ out_data) == RSP_SYM_ZERO && syn1_next == RSP_SYM_ZERO)
        else $error("codeword not divisible by generator");

    c_codeword_done: cover property (@(posedge clk) disable iff (!rstn)
        out_valid && out_last);

    c_back_to_back: cover property (@(posedge clk) disable iff (!rstn)
        out_last ##1 out_valid && !out_par);

    a_ready_at_last: assert property (@(posedge clk) disable iff (!rstn)
        out_valid && out_last |-> in_ready)
        else $error("not ready after final parity");

    c_inv_of_zero: cover property (@(posedge clk) disable iff (!rstn)
        inv_a == RSP_SYM_ZERO ##1 inv_q == RSP_SYM_ZERO);

    c_wrap_product: cover property (@(posedge clk) disable iff (!rstn)
        mul_a == 10'h200 && mul_b == RSP_ALPHA ##1 mul_p == 10'h009);

    c_gap_after_word: cover property (@(posedge clk) disable iff (!rstn)
        out_last ##1 !out_valid);

endmodule
`default_nettype wire

// ### dv/rsp_partner.sv
`timescale 1ns/10ps
`default_nettype none
module rsp_partner (
    // clock
    input wire logic clk,
    // message stream
    output logic in_valid,
    input wire logic in_ready,
    output logic [9:0] in_data,
    output logic in_last,
    // codeword stream
    input wire logic out_valid,
    input wire logic [9:0] out_data,
    input wire logic out_last,
    input wire logic out_par
);
    logic [9:0] cw[$];
    logic [1:0] fl[$];

    initial begin
        in_valid = 1'b0;
        in_data = 10'h155;
        in_last = 1'b0;
    end

    // sink never stalls
    always @(posedge clk) begin
        if (out_valid) begin
            cw.push_back(out_data);
            fl.push_back({out_last, out_par});
        end
    end

    // entries are {last, symbol}; request held until taken
    task automatic send(input logic [10:0] m[$], input int gap, output bit tmo);
        tmo = 1'b0;
        @(posedge clk);
        foreach (m[i]) begin
            in_valid <= 1'b1;
            in_data <= m[i][9:0];
            in_last <= m[i][10];
            for (int w = 0; w <= 40; w++) begin
                @(posedge clk);
                if (in_ready) break;
                if (w == 40) tmo = 1'b1;
            end
            if (gap > 0 || i == m.size() - 1) begin
                in_valid <= 1'b0;
                in_last <= 1'b0;
                in_data <= ~m[i][9:0];
                repeat (gap) @(posedge clk);
            end
        end
    endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk, rstn, in_valid, in_ready, in_last, out_valid, out_last, out_par;
    logic [9:0] in_data, out_data, mul_a, mul_b, mul_p, inv_a, inv_q;
    logic [10:0] q1[$], q2[$];
    int error_cnt = 0;
    int num_checks = 0;
    logic [9:0] gen[10] = '{10'h0a9, 10'h1f2, 10'h3e5, 10'h1cf, 10'h1d0, 10'h396, 10'h2a5, 10'h0af, 10'h0c3, 10'h3ff};

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    rsp_encoder i_rsp_encoder (.clk(clk), .rstn(rstn), .in_valid(in_valid), .in_ready(in_ready),
        .in_data(in_data), .in_last(in_last), .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last), .out_par(out_par), .mul_a(mul_a), .mul_b(mul_b), .mul_p(mul_p),
        .inv_a(inv_a), .inv_q(inv_q));
    rsp_partner i_rsp_partner (.clk(clk), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
        .in_last(in_last), .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
        .out_par(out_par));

    // ****************************************
    // helpers
    // ****************************************
    // shift-and-add product, reduced by x^10 + x^3 + 1
    function automatic logic [9:0] gm(input logic [9:0] a, input logic [9:0] b);
        logic [9:0] r;
        r = '0;
        for (int i = 9; i >= 0; i--) begin
            r = {r[8:0], 1'b0} ^ (r[9] ? 10'h009 : 10'h000);
            if (b[i]) r = r ^ a;
        end
        return r;
    endfunction

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        #1;
        chk({in_ready, out_valid, out_last, out_par}, 10'h008);
        chk(mul_p, 10'h000);
        chk(inv_q, 10'h000);
    endtask

    task automatic t_mid_reset();
        logic [10:0] m[$];
        bit tmo;
        m.push_back(11'h5a5);
        i_rsp_partner.send(m, 0, tmo);
        repeat (3) @(posedge clk);
        rstn <= 1'b0;
        t_reset();
        @(posedge clk);
        rstn <= 1'b1;
        chk(10'(tmo), 10'h000);
    endtask

    task automatic t_mul();
        logic [9:0] a, b;
        for (int k = 0; k < 16; k++) begin
            a = 10'(k * 93 + 512);
            b = 10'(1023 - k * 81);
            if (k == 0) b = 10'h002;
            if (k == 1) b = 10'h001;
            @(posedge clk);
            mul_a <= a;
            mul_b <= b;
            @(posedge clk);
            #1 chk(mul_p, gm(a, b));
        end
    endtask

    task automatic t_inv();
        logic [9:0] a;
        for (int k = 0; k < 16; k++) begin
            a = 10'(k * 67 + k / 15 * 58);
            @(posedge clk);
            inv_a <= a;
            @(posedge clk);
            #1 chk((a == 0) ? inv_q : gm(a, inv_q), (a == 0) ? 10'h000 : 10'h001);
        end
    endtask

    task automatic t_enc(input logic [10:0] m[$], input int gap);
        logic [9:0] rem[10], ap[10], h[10], exp[$], fb;
        logic [1:0] ef[$];
        bit tmo;
        int n;
        rem = '{default: '0};
        foreach (m[i]) begin
            exp.push_back(m[i][9:0]);
            ef.push_back(2'b00);
            fb = m[i][9:0] ^ rem[9];
            for (int j = 9; j > 0; j--) rem[j] = rem[j-1] ^ gm(fb, gen[j]);
            rem[0] = gm(fb, gen[0]);
            if (m[i][10]) begin
                for (int j = 9; j >= 0; j--) begin
                    exp.push_back(rem[j]);
                    ef.push_back({j == 0, 1'b1});
                end
                rem = '{default: '0};
            end
        end
        i_rsp_partner.cw.delete();
        i_rsp_partner.fl.delete();
        i_rsp_partner.send(m, gap, tmo);
        for (n = 0; n < 200 && i_rsp_partner.cw.size() < exp.size(); n++) @(posedge clk);
        if (tmo || n == 200) begin
            error_cnt++;
            stop_test();
        end
        ap[0] = 10'h001;
        for (int k = 1; k < 10; k++) ap[k] = gm(ap[k-1], 10'h002);
        h = '{default: '0};
        foreach (exp[i]) begin
            chk(i_rsp_partner.cw[i], exp[i]);
            chk(i_rsp_partner.fl[i], ef[i]);
            for (int k = 0; k < 10; k++) h[k] = gm(h[k], ap[k]) ^ i_rsp_partner.cw[i];
            if (ef[i][1]) begin
                for (int k = 0; k < 10; k++) chk(h[k], 10'h000);
                h = '{default: '0};
            end
        end
        chk(10'(i_rsp_partner.cw.size()), 10'(exp.size()));
    endtask

    initial begin
        rstn = 1'b0;
        mul_a = '0;
        mul_b = '0;
        inv_a = '0;
        repeat (9) @(posedge clk);
        t_reset();
        @(posedge clk);
        rstn <= 1'b1;
        t_mul();
        t_inv();
        q1.push_back(11'h7ff);
        for (int k = 0; k < 20; k++) q1.push_back({k == 19, 10'(k * 77 + 5)});
        q1.push_back(11'h400);
        t_enc(q1, 0);
        t_mid_reset();
        for (int k = 0; k < 7; k++) q2.push_back({k == 6, 10'(1000 - k * 131)});
        t_enc(q2, 2);
        stop_test();
    end
endmodule
`default_nettype wire
